// >>> verilog/sit_timer.sv
// Purpose: 8-bit interval timer behind a simple register port
// Assumes: Single 100 MHz clock, read data one cycle after read strobe
// Notes:   Slow source pin is synchronised in sit_tick_sync
//
// Operation
// - Every reset clears reload and count registers
// - Reload/count writes dropped while timer runs
// - Reload readable at any time; count reads zero in slow mode until valid
// - Reload register holds 8-bit overflow value
// - Count register loadable and readable, 8 bits
// - Match sets sticky flag until cleared
// - Match interrupt request on match_irq_out only while enable set; irq_out follows match and dropped-write status under mask regardless
// - Slow source reads zero until count valid
`timescale 1ns/1ps
`default_nettype none
module sit_timer
	import sit_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  clk_en_in,
	input  wire logic [SIT_ADDR_W-1:0] addr_in,
	input  wire logic [SIT_DATA_W-1:0] wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	input  wire logic                  slow_clk_in,
	output logic      [SIT_DATA_W-1:0] rdata_out,
	output logic                       match_irq_out,
	output logic                       irq_out
);
	// ****************************************************
	// State
	// ****************************************************
	logic [SIT_DATA_W-1:0] timer_reload_value;
	logic [SIT_DATA_W-1:0] timer_current_count;
	logic                  timer_clock_enable;
	logic                  slow_select;
	logic                  timer_match_flag;
	logic                  timer_match_irq_enable;
	logic                  count_valid;
	logic [1:0]            valid_cnt;
	logic [SIT_IRQ_N-1:0]  irq_stat;
	logic [SIT_IRQ_N-1:0]  irq_mask;
	logic                  slow_rise;
	logic                  tick;
	logic                  match;
	logic                  wr_reload;
	logic                  wr_count;
	logic                  wr_dropped;
	logic                  wr_ctrl;
	logic [SIT_DATA_W-1:0] next_rdata;

	function automatic logic hit(input logic [SIT_ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	sit_tick_sync u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.clk_en_in  (clk_en_in),
		.pin_in     (slow_clk_in),
		.rise_out   (slow_rise)
	);

	assign tick       = timer_clock_enable & (slow_select ? slow_rise : 1'b1);
	assign match      = tick & (timer_current_count == timer_reload_value);
	assign wr_reload  = wr_in & hit(addr_in, SIT_OFF_RELOAD) & ~timer_clock_enable;
	assign wr_count   = wr_in & hit(addr_in, SIT_OFF_COUNT) & ~timer_clock_enable;
	assign wr_dropped = wr_in & timer_clock_enable
		& (hit(addr_in, SIT_OFF_RELOAD) | hit(addr_in, SIT_OFF_COUNT));
	assign wr_ctrl    = wr_in & hit(addr_in, SIT_OFF_CTRL);

	// ****************************************************
	// Reload and count
	// ****************************************************
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_reload_value <= SIT_RST_BYTE;
		end else if (clk_en_in && wr_reload) begin
			timer_reload_value <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_current_count <= SIT_RST_BYTE;
		end else if (clk_en_in) begin
			if (wr_count) begin
				timer_current_count <= wdata_in;
			end else if (match) begin
				timer_current_count <= SIT_RST_BYTE;
			end else if (tick) begin
				timer_current_count <= timer_current_count + SIT_ONE_BYTE;
			end
		end
	end

	// ****************************************************
	// Control
	// ****************************************************
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_clock_enable     <= 1'b0;
			slow_select            <= 1'b0;
			timer_match_irq_enable <= 1'b0;
		end else if (clk_en_in && wr_ctrl) begin
			timer_clock_enable     <= wdata_in[SIT_CTRL_RUN];
			slow_select            <= wdata_in[SIT_CTRL_SLOW];
			timer_match_irq_enable <= wdata_in[SIT_CTRL_IE];
		end
	end

	// Flag set wins over software clear (write zero to bit)
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_match_flag <= 1'b0;
		end else if (clk_en_in) begin
			if (match) begin
				timer_match_flag <= 1'b1;
			end else if (wr_ctrl && !wdata_in[SIT_CTRL_FLAG]) begin
				timer_match_flag <= 1'b0;
			end
		end
	end

	// Count valid after a few slow ticks of running
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			valid_cnt   <= 2'h0;
			count_valid <= 1'b0;
		end else if (clk_en_in) begin
			if (!timer_clock_enable || !slow_select) begin
				valid_cnt   <= 2'h0;
				count_valid <= 1'b0;
			end else if (slow_rise && !count_valid) begin
				valid_cnt <= valid_cnt + 2'h1;
				if (valid_cnt == 2'(SIT_VALID_TICKS - 1)) begin
					count_valid <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// Interrupt status and mask
	// ****************************************************
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_stat <= '0;
		end else if (clk_en_in) begin
			for (int i = 0; i < SIT_IRQ_N; i++) begin
				if ((i == SIT_IRQ_MATCH && match) || (i == SIT_IRQ_WRDROP && wr_dropped)) begin
					irq_stat[i] <= 1'b1;
				end else if (wr_in && hit(addr_in, SIT_OFF_IRQ_STAT) && wdata_in[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_mask <= '0;
		end else if (clk_en_in && wr_in && hit(addr_in, SIT_OFF_IRQ_MASK)) begin
			irq_mask <= wdata_in[SIT_IRQ_N-1:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_out       <= 1'b0;
			match_irq_out <= 1'b0;
		end else if (clk_en_in) begin
			irq_out       <= |(irq_stat & irq_mask);
			match_irq_out <= timer_match_flag & timer_match_irq_enable;
		end
	end

	// ****************************************************
	// Read port
	// ****************************************************
	always_comb begin
		next_rdata = SIT_RST_BYTE;
		case (addr_in)
			SIT_OFF_RELOAD: begin
				next_rdata = timer_reload_value;
			end
			SIT_OFF_COUNT: begin
				if (!slow_select || count_valid) begin
					next_rdata = timer_current_count;
				end
			end
			SIT_OFF_CTRL: begin
				next_rdata[SIT_CTRL_RUN]   = timer_clock_enable;
				next_rdata[SIT_CTRL_SLOW]  = slow_select;
				next_rdata[SIT_CTRL_VALID] = count_valid;
				next_rdata[SIT_CTRL_FLAG]  = timer_match_flag;
				next_rdata[SIT_CTRL_IE]    = timer_match_irq_enable;
			end
			SIT_OFF_IRQ_STAT: begin
				next_rdata[SIT_IRQ_N-1:0] = irq_stat;
			end
			SIT_OFF_IRQ_MASK: begin
				next_rdata[SIT_IRQ_N-1:0] = irq_mask;
			end
			default: begin
				next_rdata = SIT_RST_BYTE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= SIT_RST_BYTE;
		end else if (clk_en_in) begin
			rdata_out <= rd_in ? next_rdata : SIT_RST_BYTE;
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	reset_clear_a: assert property (@(posedge clk_sys_in) $rose(rst_n_in) |->
		timer_reload_value == 8'h00 && timer_current_count == 8'h00)
		else $error("registers not cleared by reset");
	write_guard_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_in && timer_clock_enable && addr_in == SIT_OFF_RELOAD
		|=> $stable(timer_reload_value))
		else $error("reload written while running");
	read_any_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && rd_in && addr_in == SIT_OFF_RELOAD |=> rdata_out == $past(timer_reload_value))
		else $error("reload read wrong");
	reload_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_in && !timer_clock_enable && addr_in == SIT_OFF_RELOAD
		|=> timer_reload_value == $past(wdata_in))
		else $error("reload not loaded");
	count_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_count |=> timer_current_count == $past(wdata_in))
		else $error("count not loaded");
	match_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && match |=> timer_match_flag)
		else $error("match flag not set");
	irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && !timer_match_irq_enable |=> !match_irq_out)
		else $error("irq without enable");
	slow_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && rd_in && addr_in == SIT_OFF_COUNT && slow_select && !count_valid
		|=> rdata_out == 8'h00)
		else $error("invalid slow count read nonzero");
	count_step_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && tick && !match && !wr_count
		|=> timer_current_count == $past(timer_current_count) + 8'h01)
		else $error("count did not step");
	count_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && match && !wr_count |=> timer_current_count == 8'h00)
		else $error("count did not wrap");

	// ****************************************************
	// Checks: hold, read and interrupt paths
	// ****************************************************
	count_guard_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_in && timer_clock_enable && addr_in == SIT_OFF_COUNT
		|=> timer_current_count == SIT_RST_BYTE
			|| timer_current_count == $past(timer_current_count)
			|| timer_current_count == $past(timer_current_count) + SIT_ONE_BYTE)
		else $error("count written while running");
	drop_status_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_dropped |=> irq_stat[SIT_IRQ_WRDROP])
		else $error("dropped write not flagged");
	count_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && rd_in && addr_in == SIT_OFF_COUNT && (!slow_select || count_valid)
		|=> rdata_out == $past(timer_current_count))
		else $error("count read wrong");
	reload_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && !wr_reload |=> $stable(timer_reload_value))
		else $error("reload changed without write");
	flag_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && timer_match_flag && !(wr_ctrl && !wdata_in[SIT_CTRL_FLAG])
		|=> timer_match_flag)
		else $error("match flag lost");
	flag_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_ctrl && !wdata_in[SIT_CTRL_FLAG] && !match
		|=> !timer_match_flag)
		else $error("match flag not cleared");
	match_status_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && match |=> irq_stat[SIT_IRQ_MATCH])
		else $error("match status not set");
	irq_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && timer_match_flag && timer_match_irq_enable |=> match_irq_out)
		else $error("enabled match irq missing");
	count_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && !timer_clock_enable && !wr_count |=> $stable(timer_current_count))
		else $error("count moved while stopped");
	slow_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && timer_clock_enable && slow_select && !slow_rise && !wr_count
		|=> $stable(timer_current_count))
		else $error("slow count moved without tick");
	valid_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && !slow_select |=> !count_valid)
		else $error("count valid while fast");
	rdata_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && !rd_in |=> rdata_out == SIT_RST_BYTE)
		else $error("read data not idle");
	mask_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in && wr_in && addr_in == SIT_OFF_IRQ_MASK
		|=> irq_mask == $past(wdata_in[SIT_IRQ_N-1:0]))
		else $error("mask not loaded");
	irq_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		clk_en_in |=> irq_out == (|$past(irq_stat & irq_mask)))
		else $error("irq level wrong");
	freeze_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!clk_en_in |=> $stable(timer_reload_value) && $stable(timer_current_count)
			&& $stable(rdata_out) && $stable(irq_out) && $stable(match_irq_out))
		else $error("state moved while frozen");
endmodule
`default_nettype wire

// >>> verilog/sit_pkg.sv
// Purpose: Constants for the special-function-register interval timer
// Assumes: 8-bit register port, 100 MHz system clock
// Notes:   Control and interrupt registers sit at offsets of our own
package sit_pkg;
	localparam int         SIT_ADDR_W       = 8;
	localparam int         SIT_DATA_W       = 8;
	localparam logic [7:0] SIT_OFF_RELOAD   = 8'h05;
	localparam logic [7:0] SIT_OFF_COUNT    = 8'h06;
	localparam logic [7:0] SIT_OFF_CTRL     = 8'h07;
	localparam logic [7:0] SIT_OFF_IRQ_STAT = 8'h0a;
	localparam logic [7:0] SIT_OFF_IRQ_MASK = 8'h0b;
	localparam logic [7:0] SIT_RST_BYTE     = 8'h00;
	localparam logic [7:0] SIT_ONE_BYTE     = 8'h01;
	// Control register bit positions
	localparam int         SIT_CTRL_RUN     = 0;
	localparam int         SIT_CTRL_SLOW    = 1;
	localparam int         SIT_CTRL_VALID   = 5;
	localparam int         SIT_CTRL_FLAG    = 6;
	localparam int         SIT_CTRL_IE      = 7;
	// Interrupt status bit positions
	localparam int         SIT_IRQ_MATCH    = 0;
	localparam int         SIT_IRQ_WRDROP   = 1;
	localparam int         SIT_IRQ_N        = 2;
	// Slow source and valid delay
	localparam int         SIT_SYNC_STAGES  = 3;
	localparam int         SIT_VALID_TICKS  = 2;
endpackage

// >>> verilog/sit_tick_sync.sv
// Purpose: Brings the 32 kHz source pin into the system domain as a tick
// Assumes: Pin is asynchronous to clk_sys_in
// Notes:   Three flops, edge counted once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sit_tick_sync
	import sit_pkg::*;
(
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	input  wire logic clk_en_in,
	input  wire logic pin_in,
	output logic      rise_out
);
	logic [SIT_SYNC_STAGES-1:0] sync_q;
	logic                       level_q;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_q <= '0;
		end else if (clk_en_in) begin
			sync_q <= {sync_q[SIT_SYNC_STAGES-2:0], pin_in};
		end
	end

	// Level only moves when stages two and three agree
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_q  <= 1'b0;
			rise_out <= 1'b0;
		end else if (clk_en_in) begin
			rise_out <= 1'b0;
			if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
				level_q  <= sync_q[2];
				rise_out <= sync_q[2];
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/sit_core_model.sv
// Purpose: Core-side register master for the interval timer
// Assumes: Strobes launched by non-blocking assignment after a rising edge
// Notes:   Each access takes two cycles; released bus shows inverted values
`timescale 1ns/1ps
`default_nettype none
module sit_core_model
	import sit_pkg::*;
(
	input  wire logic                  clk_sys_in,
	output logic      [SIT_ADDR_W-1:0] addr_out,
	output logic      [SIT_DATA_W-1:0] wdata_out,
	output logic                       wr_out,
	output logic                       rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge clk_sys_in);
		wr_out <= 1'h0;
		addr_out <= ~a;
		wdata_out <= ~d;
		@(posedge clk_sys_in);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge clk_sys_in);
		rd_out <= 1'h0;
		addr_out <= ~a;
		@(posedge clk_sys_in);
	endtask
endmodule
`default_nettype wire

// >>> sim/sit_timer_tb.sv
// Purpose: Self-checking bench for the interval timer
// Assumes: Core model drives the register port
// Notes:   Read results checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module sit_timer_tb;
	import sit_pkg::*;
	logic        clk_sys_in, rst_n_in, clk_en_in, slow_clk_in, rd_d;
	logic        wr, rd, match_irq_out, irq_out;
	logic [7:0]  addr, wdata, rdata_out, r;
	logic [15:0] exp_q[$];
	logic [15:0] e_pop;
	int          bad_count, total_checks, cyc, n;
	sit_core_model i_core (.clk_sys_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	sit_timer i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.slow_clk_in(slow_clk_in), .rdata_out(rdata_out),
		.match_irq_out(match_irq_out), .irq_out(irq_out));
	initial begin
		clk_sys_in = 1'h0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			bad_count++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic expect_rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		exp_q.push_back({m, e});
		i_core.rd_reg(a);
	endtask
	// ****************************************
	// Read monitor and timeout
	// ****************************************
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		rd_d <= rd;
		if (rd_d && exp_q.size() > 0) begin
			e_pop = exp_q.pop_front();
			check(rdata_out & e_pop[15:8], e_pop[7:0]);
		end
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst_n_in = 1'h0;
		clk_en_in = 1'h1;
		slow_clk_in = 1'h0;
		rd_d = 1'h0;
		cyc = 0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'h11728eef));
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		@(posedge clk_sys_in);
		r = 8'h03 + 8'($urandom % 8);
		expect_rd(SIT_OFF_RELOAD, 8'h00);
		expect_rd(SIT_OFF_COUNT, 8'h00);
		expect_rd(8'h20, 8'h00);
		i_core.wr_reg(SIT_OFF_RELOAD, r);
		i_core.wr_reg(SIT_OFF_COUNT, 8'h01);
		expect_rd(SIT_OFF_RELOAD, r);
		expect_rd(SIT_OFF_COUNT, 8'h01);
		i_core.wr_reg(SIT_OFF_COUNT, 8'h00);
		i_core.wr_reg(SIT_OFF_IRQ_MASK, 8'h03);
		expect_rd(SIT_OFF_IRQ_MASK, 8'h03);
		$display("register test done");
		i_core.wr_reg(SIT_OFF_CTRL, 8'h81);
		n = 0;
		while (match_irq_out !== 1'h1 && n < 40) begin
			@(posedge clk_sys_in);
			n++;
		end
		check(8'(n), r + 8'h02);
		check({7'h00, match_irq_out}, 8'h01);
		check({7'h00, irq_out}, 8'h01);
		i_core.wr_reg(SIT_OFF_RELOAD, 8'hff);
		expect_rd(SIT_OFF_RELOAD, r);
		expect_rd(SIT_OFF_IRQ_STAT, 8'h03);
		i_core.wr_reg(SIT_OFF_CTRL, 8'h41);
		@(posedge clk_sys_in);
		check({7'h00, match_irq_out}, 8'h00);
		expect_rd(SIT_OFF_CTRL, 8'h41, 8'hc1);
		i_core.wr_reg(SIT_OFF_CTRL, 8'h40);
		i_core.wr_reg(SIT_OFF_CTRL, 8'h00);
		i_core.wr_reg(SIT_OFF_IRQ_STAT, 8'h03);
		@(posedge clk_sys_in);
		check({7'h00, irq_out}, 8'h00);
		expect_rd(SIT_OFF_CTRL, 8'h00, 8'h41);
		clk_en_in <= 1'h0;
		i_core.wr_reg(SIT_OFF_RELOAD, 8'hff);
		clk_en_in <= 1'h1;
		expect_rd(SIT_OFF_RELOAD, r);
		$display("match test done");
		i_core.wr_reg(SIT_OFF_COUNT, 8'h01);
		i_core.wr_reg(SIT_OFF_CTRL, 8'h03);
		expect_rd(SIT_OFF_COUNT, 8'h00);
		repeat (6) begin
			repeat (10) @(posedge clk_sys_in);
			slow_clk_in <= ~slow_clk_in;
		end
		repeat (10) @(posedge clk_sys_in);
		expect_rd(SIT_OFF_CTRL, 8'h20, 8'h20);
		expect_rd(SIT_OFF_COUNT, (r == 8'h03) ? 8'h00 : 8'h04);
		$display("slow source test done");
		rst_n_in <= 1'h0;
		@(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		@(posedge clk_sys_in);
		expect_rd(SIT_OFF_RELOAD, 8'h00);
		expect_rd(SIT_OFF_COUNT, 8'h00);
		$display("reset test done");
		repeat (3) @(posedge clk_sys_in);
		tally_and_finish();
	end
endmodule
`default_nettype wire
